// >>> ewt_pkg.sv
package ewt_pkg;

  // ****************************************************************
  // Register map (byte offsets on the bus, byte address = index * 4)
  // ****************************************************************
  localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLOCK_CFG   = 4'h4;
  localparam logic [3:0] ADDR_COUNT_VALUE = 4'h8;
  localparam logic [3:0] ADDR_WRAP_LIMIT  = 4'hC;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FLAG_BIT  = 7;
  localparam int IRQEN_BIT = 6;
  localparam int CLEAR_BIT = 5;
  localparam int HALT_BIT  = 4;
  localparam int SRC_HI    = 5;
  localparam int SRC_LO    = 4;
  localparam int PS_HI     = 3;
  localparam int PS_LO     = 0;

  // ****************************************************************
  // Reset values and encodings
  // ****************************************************************
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [1:0] SRC_RESET   = 2'h0;
  localparam logic [3:0] PS_RESET    = 4'h0;
  localparam logic [3:0] PS_MAX      = 4'h8;
  localparam logic [1:0] SRC_BUS     = 2'h0;
  localparam logic [1:0] SRC_FIXED   = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL = 2'h2;
  localparam logic [1:0] SRC_EXT_RISE = 2'h3;

  // Bus answer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ewt_bus_t;

endpackage : ewt_pkg

// >>> ewt_timer.sv
`timescale 1ns/100ps
module ewt_timer (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [0:0]  WB_SEL_I,
  input  wire logic [7:0]  WB_DAT_I,
  output logic      [7:0]  WB_DAT_O,
  output logic             WB_ACK_O,
  // Timer pins and system modes
  input  wire logic        REF_FIXED_CLOCK,
  input  wire logic        EXT_TIMER_CLOCK_IN,
  input  wire logic        STOP_MODE,
  input  wire logic        DEBUG_ACTIVE,
  // Interrupt request
  output logic             OVERFLOW_IRQ
);

  // ****************************************************************
  // Usage notes
  // ****************************************************************
  // Bus timing
  // - Request taken on the edge where cycle and strobe are high
  // - Ack stands for exactly one cycle after that edge; read data holds until the next request
  // - A strobe held through ack is not taken twice; idle one cycle
  // - Writes with the byte lane off are acked but change nothing
  // - Unmapped reads return zero; unmapped writes are ignored
  // Counting
  // - Limit of zero runs the full range, otherwise zero up to limit
  // - Clear bit and any limit write also zero the prescaler,
  //   so the first period after a clear is always a full one
  // - Source and prescale changes keep the count; the prescaler
  //   is not cleared either, so the first period after a change
  //   may be short
  // - Count register writes are ignored without error
  // - Pin edges lag the pin by three cycles through the synchroniser
  // - A pin faster than a quarter of the bus rate loses edges
  // - Reference clock is sampled; it must stay below half bus rate
  // Flag and interrupt
  // - Flag write-zero clears only after a status read saw it set; clear bit and limit writes clear it without a read
  // - A wrap in the same cycle as any clear leaves the flag set
  // - Clear bit always reads back as zero
  // - Interrupt line changes in the same cycle as flag and enable
  // Power modes
  // - Stop and debug freeze the count and the prescaler
  // - Nothing in this block wakes the core from stop
  // - Leaving stop through reset is the ordinary async reset
  // - Wait is not seen here; the timer simply keeps running
  // Limitations
  // - One byte lane only; wider accesses see the low byte
  // - No wake output; the core sees only the interrupt level
  // - Fixed source needs the reference in its valid mode


  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Prescale code to tap; codes above eight saturate at 256
  function automatic logic [3:0] ps_tap(input logic [3:0] code);
    ps_tap = (code > ewt_pkg::PS_MAX) ? ewt_pkg::PS_MAX : code;
  endfunction : ps_tap

  // Address match, used by every decode except the read mux
  function automatic logic hit(input logic [3:0] adr,
                               input logic [3:0] want);
    hit = (adr == want);
  endfunction : hit

  // ****************************************************************
  // State
  // ****************************************************************
  // Counter, limit and control fields
  logic [7:0] count_q, count_d;
  logic [7:0] limit_q, limit_d;
  logic       flag_q, flag_d;
  logic       irqen_q, irqen_d;
  logic       halt_q, halt_d;
  logic [1:0] src_q, src_d;
  logic [3:0] ps_q, ps_d;
  // Flag clear handshake and prescaler
  logic       flag_seen_q, flag_seen_d;
  logic [7:0] pre_q, pre_d;
  // Source edge detectors and synchroniser
  logic       fix_div_q, fix_div_d;
  logic       fix_prev_q, fix_prev_d;
  logic       ext_s1_q, ext_s2_q, ext_prev_q;
  // Registered outputs and bus state
  logic       irq_q, irq_d;
  logic [7:0] rdata_q, rdata_d;
  ewt_pkg::ewt_bus_t bus_q, bus_d;

  // Combinational helpers
  logic       req, wr, rd;
  logic       src_edge, tick, wrap, reset_cnt;
  logic [8:0] pre_taps;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // One-cycle ack; a new request is only taken when idle
  assign req = WB_CYC_I & WB_STB_I & (bus_q == ewt_pkg::BUS_IDLE);
  assign wr  = req & WB_WE_I & WB_SEL_I[0];
  assign rd  = req & ~WB_WE_I;

  // ****************************************************************
  // Source selection
  // ****************************************************************
  // Pin is only ever read through the second synchroniser stage
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_s1_q   <= EXT_TIMER_CLOCK_IN;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // Edge pick; external pin assumed below a quarter of bus rate
  always_comb begin
    fix_prev_d = REF_FIXED_CLOCK;
    fix_div_d  = fix_div_q ^ (REF_FIXED_CLOCK & ~fix_prev_q);
    case (src_q)
      ewt_pkg::SRC_BUS:      src_edge = 1'b1;
      ewt_pkg::SRC_FIXED:    src_edge = fix_div_d & ~fix_div_q;
      ewt_pkg::SRC_EXT_FALL: src_edge = ext_prev_q & ~ext_s2_q;
      ewt_pkg::SRC_EXT_RISE: src_edge = ext_s2_q & ~ext_prev_q;
      default:               src_edge = 1'b0;
    endcase
  end

  // ****************************************************************
  // Prescaler and counter
  // ****************************************************************
  // Stop and debug freeze the count and the prescaler; nothing here wakes from stop
  // Run gate shared by prescaler and counter
  logic run;
  assign run       = ~halt_q & ~STOP_MODE & ~DEBUG_ACTIVE;
  assign reset_cnt = (wr & hit(WB_ADR_I, ewt_pkg::ADDR_STATUS_CTRL)
                      & WB_DAT_I[ewt_pkg::CLEAR_BIT])
                   | (wr & hit(WB_ADR_I, ewt_pkg::ADDR_WRAP_LIMIT));

  // Tap k fires when the low k bits of the divider roll over
  genvar k;
  // Tap zero is the undivided source
  assign pre_taps[0] = 1'b1;
  generate
    for (k = 1; k < 9; k = k + 1) begin : g_tap
      assign pre_taps[k] = &pre_q[k-1:0];
    end
  endgenerate

  assign tick = run & src_edge & pre_taps[ps_tap(ps_q)];
  // Limit of zero gives the free-running full range
  assign wrap = tick & ((limit_q == ewt_pkg::LIMIT_RESET) ?
                        (count_q == 8'hFF) : (count_q == limit_q));

  // Prescaler and count next values; clear beats counting
  always_comb begin
    pre_d   = pre_q;
    count_d = count_q;
    if (reset_cnt) begin
      pre_d   = 8'h00;
      count_d = ewt_pkg::COUNT_RESET;
    end else if (run & src_edge) begin
      pre_d = pre_q + 8'h01;
      if (tick) begin
        count_d = wrap ? ewt_pkg::COUNT_RESET : count_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Next values of the control fields and the flag
  always_comb begin
    limit_d     = limit_q;
    irqen_d     = irqen_q;
    halt_d      = halt_q;
    src_d       = src_q;
    ps_d        = ps_q;
    flag_seen_d = flag_seen_q;
    flag_d      = flag_q;
    if (rd & hit(WB_ADR_I, ewt_pkg::ADDR_STATUS_CTRL) & flag_q) begin
      flag_seen_d = 1'b1;
    end
    if (wr & hit(WB_ADR_I, ewt_pkg::ADDR_STATUS_CTRL)) begin
      irqen_d = WB_DAT_I[ewt_pkg::IRQEN_BIT];
      halt_d  = WB_DAT_I[ewt_pkg::HALT_BIT];
      if (flag_seen_q & ~WB_DAT_I[ewt_pkg::FLAG_BIT]) begin
        flag_d      = 1'b0;
        flag_seen_d = 1'b0;
      end
    end
    if (wr & hit(WB_ADR_I, ewt_pkg::ADDR_CLOCK_CFG)) begin
      src_d = WB_DAT_I[ewt_pkg::SRC_HI:ewt_pkg::SRC_LO];
      ps_d  = WB_DAT_I[ewt_pkg::PS_HI:ewt_pkg::PS_LO];
    end
    if (wr & hit(WB_ADR_I, ewt_pkg::ADDR_WRAP_LIMIT)) begin
      limit_d = WB_DAT_I;
    end
    if (reset_cnt) begin
      flag_d      = 1'b0;
      flag_seen_d = 1'b0;
    end
    // A wrap in the clearing cycle wins
    if (wrap) begin
      flag_d = 1'b1;
    end
    irq_d = flag_d & irqen_d;
  end

  // ****************************************************************
  // Read mux and bus answer
  // ****************************************************************
  // Read data latched on the taking edge, held until the next
  always_comb begin
    bus_d   = ewt_pkg::BUS_IDLE;
    rdata_d = rdata_q;
    if (req) begin
      bus_d = ewt_pkg::BUS_ACK;
      case (WB_ADR_I)
        ewt_pkg::ADDR_STATUS_CTRL:
          rdata_d = {flag_q, irqen_q, 1'b0, halt_q, 4'h0};
        ewt_pkg::ADDR_CLOCK_CFG:   rdata_d = {2'h0, src_q, ps_q};
        ewt_pkg::ADDR_COUNT_VALUE: rdata_d = count_q;
        ewt_pkg::ADDR_WRAP_LIMIT:  rdata_d = limit_q;
        default:                   rdata_d = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Async reset returns every field; halt set, irq enable cleared
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      count_q     <= ewt_pkg::COUNT_RESET;
      limit_q     <= ewt_pkg::LIMIT_RESET;
      flag_q      <= 1'b0;
      irqen_q     <= 1'b0;
      halt_q      <= 1'b1;
      src_q       <= ewt_pkg::SRC_RESET;
      ps_q        <= ewt_pkg::PS_RESET;
      flag_seen_q <= 1'b0;
      pre_q       <= 8'h00;
      fix_div_q   <= 1'b0;
      fix_prev_q  <= 1'b0;
      irq_q       <= 1'b0;
      rdata_q     <= 8'h00;
      bus_q       <= ewt_pkg::BUS_IDLE;
    end else begin
      count_q     <= count_d;
      limit_q     <= limit_d;
      flag_q      <= flag_d;
      irqen_q     <= irqen_d;
      halt_q      <= halt_d;
      src_q       <= src_d;
      ps_q        <= ps_d;
      flag_seen_q <= flag_seen_d;
      pre_q       <= pre_d;
      fix_div_q   <= fix_div_d;
      fix_prev_q  <= fix_prev_d;
      irq_q       <= irq_d;
      rdata_q     <= rdata_d;
      bus_q       <= bus_d;
    end
  end


  // Outputs taken straight from their flops
  assign WB_DAT_O     = rdata_q;
  assign WB_ACK_O     = (bus_q == ewt_pkg::BUS_ACK);
  assign OVERFLOW_IRQ = irq_q;

endmodule : ewt_timer

// >>> ewt_timer_checker.sv
`timescale 1ns/100ps
module ewt_timer_checker (
  // Clock and reset
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  // Bus and interrupt
  input wire logic       WB_CYC_I,
  input wire logic       WB_STB_I,
  input wire logic       WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [0:0] WB_SEL_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic [7:0] WB_DAT_O,
  input wire logic       WB_ACK_O,
  input wire logic       OVERFLOW_IRQ
);
  // ****************************************************************
  // Bus answer and read-back checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);
  // Read answer on the bus
  wire logic rd_ack = WB_ACK_O && !WB_WE_I;
  chk_ack_follows:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("Request not answered in next cycle");
  chk_ack_single:
    assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Ack held longer than one cycle");
  chk_ack_cause:
    assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("Ack without request");
  chk_status_zeros:
    assert property (rd_ack && WB_ADR_I == 4'h0 |-> WB_DAT_O[5] == 1'b0
                     && WB_DAT_O[3:0] == 4'h0)
    else $error("Status unused bits not zero");
  chk_cfg_zeros:
    assert property (rd_ack && WB_ADR_I == 4'h4 |-> WB_DAT_O[7:6] == 2'h0)
    else $error("Clock config upper bits not zero");
  chk_hole_zero:
    assert property (rd_ack && !(WB_ADR_I inside {4'h0, 4'h4, 4'h8, 4'hC})
                     |-> WB_DAT_O == 8'h00)
    else $error("Unmapped read not zero");
  chk_irq_follow:
    assert property (rd_ack && WB_ADR_I == 4'h0 && WB_DAT_O[7:6] == 2'h3
                     |-> ##[0:2] OVERFLOW_IRQ)
    else $error("Irq low with flag and enable set");
  chk_irq_off:
    assert property (WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 4'h0
                     && !WB_DAT_I[6] |-> ##[1:2] !OVERFLOW_IRQ)
    else $error("Irq high with enable cleared");
endmodule : ewt_timer_checker
bind ewt_timer ewt_timer_checker ewt_timer_checker_inst (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .OVERFLOW_IRQ(OVERFLOW_IRQ));

// >>> ewt_timer_tb_top.sv
`timescale 1ns/100ps
module ewt_timer_tb_top;
  logic       clk, rst_b, cyc, stb, we, ref_c, ext_c, stop_m, dbg, ack, irq;
  logic [3:0] adr;
  logic [7:0] dwr, dat_o, rdat, c0, tick;
  int         err_count, total_checks;
  // Clock config per case and expected count after one timed run
  localparam logic [7:0] CFG [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0F, 8'h10, 8'h20, 8'h30};
  localparam int EXP [14] = '{202, 101, 50, 25, 12, 6, 3, 1, 0, 0, 0, 25, 25,
    25};
  ewt_timer ewt_timer_inst (.CORE_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(1'b1),
    .WB_DAT_I(dwr), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .REF_FIXED_CLOCK(ref_c),
    .EXT_TIMER_CLOCK_IN(ext_c), .STOP_MODE(stop_m), .DEBUG_ACTIVE(dbg),
    .OVERFLOW_IRQ(irq));
  // Bus clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pin clock at 1/8 bus rate keeps inside the sync limit
  always @(posedge clk) begin
    tick  <= tick + 8'h01;
    ref_c <= tick[1];
    ext_c <= tick[2];
  end
  task complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Tolerant compare: bus latency blurs the run length by a few cycles
  task near(input logic [7:0] got, input int exp);
    total_checks++;
    if ((got + 3 >= exp && got <= exp + 3) !== 1'b1) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : near
  // One classic cycle; ack is sampled at the edge
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dwr <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      complete_run();
    end
  endtask : wb
  task rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    check(rdat, e);
  endtask : rd
  task run(input int n);
    wb(1'b1, 4'h0, 8'h00);
    repeat (n) @(posedge clk);
    wb(1'b1, 4'h0, 8'h10);
  endtask : run
  initial begin
    {rst_b, cyc, stb, we, ref_c, ext_c, stop_m, dbg} = 8'h00;
    {adr, dwr, tick, err_count, total_checks} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(4'h0, 8'h10);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'hC, 8'h00);
    wb(1'b1, 4'h2, 8'hFF);
    rd(4'h2, 8'h00);
    wb(1'b1, 4'h8, 8'h55);
    rd(4'h8, 8'h00);
    $display("Test reset_map done");
    for (int i = 0; i < 14; i++) begin
      wb(1'b1, 4'h4, CFG[i]);
      wb(1'b1, 4'h0, 8'h30);
      rd(4'h8, 8'h00);
      run(200);
      wb(1'b0, 4'h8, 8'h00);
      c0 = rdat;
      near(c0, EXP[i]);
      wb(1'b1, 4'h4, 8'h00);
      rd(4'h8, c0);
    end
    $display("Test source_divider done");
    wb(1'b1, 4'hC, 8'h03);
    rd(4'h8, 8'h00);
    wb(1'b1, 4'h0, 8'h40);
    repeat (6) begin
      wb(1'b0, 4'h8, 8'h00);
      check(rdat & 8'hFC, 8'h00);
    end
    wb(1'b1, 4'h0, 8'h50);
    rd(4'h0, 8'hD0);
    check({7'h00, irq}, 8'h01);
    wb(1'b1, 4'h0, 8'h50);
    rd(4'h0, 8'h50);
    check({7'h00, irq}, 8'h00);
    $display("Test wrap_flag done");
    wb(1'b1, 4'hC, 8'h00);
    wb(1'b1, 4'h0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      stop_m <= (k == 0);
      dbg    <= (k == 1);
      wb(1'b0, 4'h8, 8'h00);
      c0 = rdat;
      repeat (10) @(posedge clk);
      rd(4'h8, c0);
      stop_m <= 1'b0;
      dbg    <= 1'b0;
      repeat (4) @(posedge clk);
      wb(1'b0, 4'h8, 8'h00);
      check({7'h00, rdat !== c0}, 8'h01);
    end
    $display("Test freeze done");
    wb(1'b1, 4'h4, 8'h13);
    wb(1'b1, 4'h0, 8'h40);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(4'h0, 8'h10);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    $display("Test mid_reset done");
    complete_run();
  end
endmodule : ewt_timer_tb_top
